// ===== rtl/adcso_pkg.sv
// Constants, types and register map of the converter serial output control block
// What this block does
// RULE_01: Select low enables data pin, wakes converter
// RULE_02: Sleep after conversion while select stays high
// RULE_03: Select rising during readout aborts, reconverts
// RULE_04: Select high keeps data pin high impedance
// RULE_05: Data pin shows status during conversion, sleep
// RULE_06: Internal mode drives serial clock during readout
// RULE_07: External mode host supplies serial clock
// RULE_08: Clock mode sampled at power up, select fall
// RULE_09: Internal mode enables weak clock pull-up
// RULE_10: Frequency pin high 50Hz, low 60Hz null
// RULE_11: Alternate variant rejects both line frequencies
// RULE_12: External clock on frequency pin is system clock
// RULE_13: Host gives 32 clock periods per word
// RULE_14: Readout ends after 32 bits or select high
// RULE_15: Data changes on falling, sampled on rising
// RULE_16: First bit high converting, low when done
// RULE_17: Internal clock gives one pulse per bit
package adcso_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000; // System clock rate
    localparam int CLK_PER_US = CLK_HZ / 1_000_000; // Cycles per microsecond
    localparam int CONV_50_US = 160230; // Conversion time, 50Hz null
    localparam int CONV_60_US = 133530; // Conversion time, 60Hz null
    localparam int CONV_ALT_US = 146710; // Conversion time, dual rejection
    localparam int CONV_50_CYC = CONV_50_US * CLK_PER_US;
    localparam int CONV_60_CYC = CONV_60_US * CLK_PER_US;
    localparam int CONV_ALT_CYC = CONV_ALT_US * CLK_PER_US;
    localparam int EXT_CONV_EDGES = 20510; // Oscillator edges per conversion
    localparam int NOTCH_DIV = 2560; // Oscillator to first null ratio
    localparam int ISCK_STD_HZ = 19200; // Internal serial clock, standard
    localparam int ISCK_ALT_HZ = 17500; // Internal serial clock, alternate
    localparam int ISCK_STD_HALF = CLK_HZ / (2 * ISCK_STD_HZ);
    localparam int ISCK_ALT_HALF = CLK_HZ / (2 * ISCK_ALT_HZ);
    localparam int EOSC_SCK_DIV = 8; // Oscillator edges per serial clock
    localparam int EOSC_HALF = EOSC_SCK_DIV / 2;
    localparam int DET_US = 400; // Oscillator presence window
    localparam int DET_CYC = DET_US * CLK_PER_US;
    localparam int WORD_BITS = 32; // Result word length
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_OFS = 8'h00; // Result value, 30 bits
    localparam logic [7:0] STATE_OFS = 8'h04; // Block state, read only
    localparam logic [7:0] IRQ_STS_OFS = 8'h08; // Sticky events, read clears
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c; // Event mask
    localparam logic [29:0] DATA_RST = 30'h0;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
    localparam int IRQ_CONV = 0; // Conversion finished
    localparam int IRQ_DONE = 1; // Full word read
    localparam int IRQ_ABORT = 2; // Readout aborted
    // Null codes
    localparam logic [1:0] NOTCH_50 = 2'h0;
    localparam logic [1:0] NOTCH_60 = 2'h1;
    localparam logic [1:0] NOTCH_BOTH = 2'h2;
    localparam logic [1:0] NOTCH_EXT = 2'h3;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_OUT} adcso_state_t;
    typedef struct packed {
        logic [1:0] notch; // Null code
        logic ext_osc; // External oscillator seen
        logic ext_sck; // External serial clock mode
        logic eoc; // Conversion running
        logic [1:0] state; // Cycle state
    } adcso_stat_t;
endpackage

// ===== rtl/adcso_ctrl.sv
// Serial output control of a delta-sigma converter with APB registers
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module adcso_ctrl import adcso_pkg::*; #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter int CONV_50 = CONV_50_CYC,
    parameter int CONV_60 = CONV_60_CYC,
    parameter int CONV_ALT = CONV_ALT_CYC,
    parameter int EXT_EDGES = EXT_CONV_EDGES,
    parameter int DET_LEN = DET_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic select_n,
    input wire logic freq_control_pin,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    output logic sck_pullup_en,
    output logic sdo_out,
    output logic sdo_oe_n,
    output logic irq
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (CONV_50 < 2 || CONV_60 < 2 || CONV_ALT < 2 || EXT_EDGES < 2 ||
        CONV_50 >= 2**22 || CONV_60 >= 2**22 || CONV_ALT >= 2**22 ||
        EXT_EDGES >= 2**22 || DET_LEN < 16 || DET_LEN >= 2**16) begin : g_bad
        $error("adcso_ctrl: counts out of range");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    adcso_state_t state_reg; // Cycle state
    logic [21:0] conv_cnt_reg; // Conversion progress
    logic [21:0] conv_len; // Conversion length for current clocking
    logic [31:0] shreg_reg; // Output word, MSB on data pin
    logic [5:0] bit_cnt_reg; // Rising clock edges in readout
    logic [8:0] half_cnt_reg; // Serial clock half period count
    logic [8:0] half_len; // Half period limit
    logic tick; // Serial clock toggle enable
    logic sel_q_reg; // Select, last cycle
    logic sck_q_reg; // Serial clock input, last cycle
    logic f0_q_reg; // Frequency pin, last cycle
    logic f0_rise; // Oscillator rising edge
    logic [15:0] det_cnt_reg; // Oscillator presence timer
    logic ext_osc_reg; // External oscillator in use
    logic ext_sck_reg; // External serial clock mode
    logic por_done_reg; // Power-up sample taken
    logic [1:0] notch_reg; // Null code
    logic k_rise; // Serial clock rising in readout
    logic k_fall; // Serial clock falling in readout
    logic [29:0] data_reg; // Result value from software
    logic [IRQ_W-1:0] sts_reg; // Sticky events
    logic [IRQ_W-1:0] mask_reg; // Event mask
    logic [IRQ_W-1:0] ev; // Events this cycle
    logic setup; // APB setup cycle
    logic acc_done; // APB access completes
    adcso_stat_t stat; // State register view

    // History is only valid after the first edge, so no false edge follows reset
    assign f0_rise = freq_control_pin & ~f0_q_reg & por_done_reg;
    assign setup = psel & ~penable;
    assign acc_done = psel & penable & pready;

    // ------------------------------------------------------------
    // Input edge history
    // ------------------------------------------------------------
    // Previous levels for edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_q_reg <= 1'b1;
            sck_q_reg <= 1'b1;
            f0_q_reg <= 1'b0;
        end else begin
            sel_q_reg <= select_n;
            sck_q_reg <= sck_in;
            f0_q_reg <= freq_control_pin;
        end
    end

    // ------------------------------------------------------------
    // Clock source and null selection
    // ------------------------------------------------------------
    // Oscillator seen when the pin toggles within the window
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            det_cnt_reg <= 16'h0;
            ext_osc_reg <= 1'b0;
        end else begin
            if (por_done_reg && freq_control_pin != f0_q_reg) begin
                det_cnt_reg <= 16'(DET_LEN);
            end else if (det_cnt_reg != 16'h0) begin
                det_cnt_reg <= det_cnt_reg - 16'h1;
            end
            ext_osc_reg <= (det_cnt_reg != 16'h0);
        end
    end

    // Null code from pin level, variant or oscillator
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            notch_reg <= NOTCH_60;
        end else if (ext_osc_reg) begin
            notch_reg <= NOTCH_EXT; // [RULE_12]
        end else if (ALT_VARIANT) begin
            notch_reg <= NOTCH_BOTH; // [RULE_11]
        end else begin
            notch_reg <= freq_control_pin ? NOTCH_50 : NOTCH_60; // [RULE_10]
        end
    end

    // Conversion length follows the selected null
    always_comb begin
        case (notch_reg)
            NOTCH_50: conv_len = 22'(CONV_50);
            NOTCH_BOTH: conv_len = 22'(CONV_ALT);
            NOTCH_EXT: conv_len = 22'(EXT_EDGES);
            default: conv_len = 22'(CONV_60);
        endcase
    end

    // ------------------------------------------------------------
    // Serial clock mode
    // ------------------------------------------------------------
    // Pin level at power up or select fall picks the mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            por_done_reg <= 1'b0;
            ext_sck_reg <= 1'b0;
            sck_pullup_en <= 1'b1;
        end else begin
            por_done_reg <= 1'b1;
            if (!por_done_reg || (sel_q_reg && !select_n)) begin
                ext_sck_reg <= ~sck_in; // [RULE_08]
            end
            sck_pullup_en <= ~ext_sck_reg; // [RULE_09]
        end
    end

    // ------------------------------------------------------------
    // Internal serial clock divider
    // ------------------------------------------------------------
    // Half period from system clock or oscillator edges
    always_comb begin
        if (ext_osc_reg) begin
            half_len = 9'(EOSC_HALF);
        end else if (ALT_VARIANT) begin
            half_len = 9'(ISCK_ALT_HALF);
        end else begin
            half_len = 9'(ISCK_STD_HALF);
        end
    end

    // Divider runs only while reading in internal mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_cnt_reg <= 9'h0;
        end else if (state_reg != ST_OUT || ext_sck_reg) begin
            half_cnt_reg <= 9'h0;
        end else if (tick) begin
            half_cnt_reg <= 9'h0;
        end else if (!ext_osc_reg || f0_rise) begin
            half_cnt_reg <= half_cnt_reg + 9'h1;
        end
    end

    assign tick = (state_reg == ST_OUT) && !ext_sck_reg && (half_cnt_reg == half_len - 9'h1)
        && (!ext_osc_reg || f0_rise);

    // Clock edges seen by the shifter, from pin or divider
    assign k_rise = (state_reg == ST_OUT) &&
        (ext_sck_reg ? (sck_in && !sck_q_reg) : (tick && !sck_out)); // [RULE_07]
    assign k_fall = (state_reg == ST_OUT) &&
        (ext_sck_reg ? (!sck_in && sck_q_reg) : (tick && sck_out));

    // Internal clock idles high, toggles once per half period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_out <= 1'b1;
            sck_oe_n <= 1'b1;
        end else begin
            if (state_reg != ST_OUT) begin
                sck_out <= 1'b1;
            end else if (tick) begin
                sck_out <= ~sck_out; // [RULE_17]
            end
            sck_oe_n <= !(state_reg == ST_OUT && !ext_sck_reg && !select_n); // [RULE_06]
        end
    end

    // ------------------------------------------------------------
    // Converter cycle
    // ------------------------------------------------------------
    // Conversion, sleep and readout sequence
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_CONV;
            conv_cnt_reg <= 22'h0;
            shreg_reg <= 32'hffffffff;
            bit_cnt_reg <= 6'h0;
        end else begin
            case (state_reg)
                ST_CONV: begin
                    if (conv_cnt_reg >= conv_len - 22'h1) begin
                        state_reg <= ST_SLEEP; // [RULE_02]
                        shreg_reg <= {2'b00, data_reg}; // [RULE_16]
                    end else if (!ext_osc_reg || f0_rise) begin
                        conv_cnt_reg <= conv_cnt_reg + 22'h1; // [RULE_12]
                    end
                end
                ST_SLEEP: begin
                    if (!select_n) begin
                        state_reg <= ST_OUT; // [RULE_01]
                        bit_cnt_reg <= 6'h0;
                    end
                end
                ST_OUT: begin
                    if (select_n) begin
                        state_reg <= ST_CONV; // [RULE_03]
                        conv_cnt_reg <= 22'h0;
                        shreg_reg <= 32'hffffffff;
                    end else if (k_rise && bit_cnt_reg == 6'(WORD_BITS - 1)) begin
                        state_reg <= ST_CONV; // [RULE_14]
                        conv_cnt_reg <= 22'h0;
                        shreg_reg <= 32'hffffffff;
                        bit_cnt_reg <= 6'(WORD_BITS);
                    end else begin
                        if (k_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 6'h1;
                        end
                        if (k_fall && bit_cnt_reg != 6'h0) begin
                            shreg_reg <= {shreg_reg[30:0], 1'b0}; // [RULE_15]
                        end
                    end
                end
                default: begin
                    state_reg <= ST_CONV;
                end
            endcase
        end
    end

    // Data pin shows status or word, released while select high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sdo_out <= 1'b1;
            sdo_oe_n <= 1'b1;
        end else begin
            sdo_out <= shreg_reg[31]; // [RULE_05]
            sdo_oe_n <= select_n; // [RULE_04]
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[IRQ_CONV] = (state_reg == ST_CONV) && (conv_cnt_reg >= conv_len - 22'h1);
        ev[IRQ_DONE] = (state_reg == ST_OUT) && !select_n && k_rise &&
            (bit_cnt_reg == 6'(WORD_BITS - 1));
        ev[IRQ_ABORT] = (state_reg == ST_OUT) && select_n;
    end

    // Sticky bits; a read clears only what it returned, new events win
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sts_reg <= '0;
            irq <= 1'b0;
        end else begin
            if (acc_done && !pwrite && paddr == IRQ_STS_OFS) begin
                sts_reg <= (sts_reg & ~prdata[IRQ_W-1:0]) | ev;
            end else begin
                sts_reg <= sts_reg | ev;
            end
            irq <= |(sts_reg & mask_reg);
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign stat = '{notch: notch_reg, ext_osc: ext_osc_reg, ext_sck: ext_sck_reg,
        eoc: (state_reg == ST_CONV), state: state_reg};

    // Read data and answer captured in the setup cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= 1'b0;
                case (paddr)
                    DATA_OFS: prdata <= {2'b00, data_reg};
                    STATE_OFS: prdata <= 32'(stat);
                    IRQ_STS_OFS: prdata <= 32'(sts_reg);
                    IRQ_MASK_OFS: prdata <= 32'(mask_reg);
                    default: begin
                        prdata <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Writes land at the completing access edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_reg <= DATA_RST;
            mask_reg <= MASK_RST;
        end else if (acc_done && pwrite) begin
            if (paddr == DATA_OFS) begin
                data_reg <= pwdata[29:0];
            end
            if (paddr == IRQ_MASK_OFS) begin
                mask_reg <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_wake;
        state_reg == ST_SLEEP && !select_n |=> state_reg == ST_OUT && !sdo_oe_n;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on select low"); // [RULE_01]

    property p_sleep_hold;
        state_reg == ST_SLEEP && select_n |=> state_reg == ST_SLEEP;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep"); // [RULE_02]

    property p_abort;
        state_reg == ST_OUT && select_n |=> state_reg == ST_CONV && conv_cnt_reg == 22'h0;
    endproperty
    a_abort: assert property (p_abort) else $error("abort failed"); // [RULE_03]

    property p_hiz;
        select_n [*2] |=> sdo_oe_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("data pin driven"); // [RULE_04]

    property p_status;
        state_reg == ST_SLEEP && $past(state_reg) == ST_SLEEP |=> !sdo_out;
    endproperty
    a_status: assert property (p_status) else $error("sleep status wrong"); // [RULE_05]

    property p_sck_drive;
        state_reg == ST_OUT && !ext_sck_reg && !select_n |=> !sck_oe_n;
    endproperty
    a_sck_drive: assert property (p_sck_drive) else $error("clock not driven"); // [RULE_06]

    property p_mode;
        sel_q_reg && !select_n |=> ext_sck_reg == !$past(sck_in) ##1 sck_pullup_en != ext_sck_reg;
    endproperty
    a_mode: assert property (p_mode) else $error("mode sample wrong"); // [RULE_08]

    property p_null;
        !ext_osc_reg && !ALT_VARIANT |=> notch_reg == ($past(freq_control_pin) ? NOTCH_50 : NOTCH_60);
    endproperty
    a_null: assert property (p_null) else $error("null code wrong"); // [RULE_10]

    property p_ext_conv;
        state_reg == ST_CONV && ext_osc_reg && !f0_rise && $past(state_reg) == ST_CONV
            |=> $stable(conv_cnt_reg);
    endproperty
    a_ext_conv: assert property (p_ext_conv) else $error("count without edge"); // [RULE_12]

    property p_word_end;
        state_reg == ST_OUT && !select_n && k_rise && bit_cnt_reg == 6'h1f |=> state_reg == ST_CONV;
    endproperty
    a_word_end: assert property (p_word_end) else $error("word end missed"); // [RULE_14]

    property p_shift;
        state_reg == ST_OUT && !select_n && k_fall && bit_cnt_reg != 6'h0
            |=> shreg_reg == {$past(shreg_reg[30:0]), 1'b0} ##1 sdo_out == $past(shreg_reg[31]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong"); // [RULE_15]

    property p_eoc;
        state_reg == ST_CONV |-> shreg_reg[31];
    endproperty
    a_eoc: assert property (p_eoc) else $error("busy bit low"); // [RULE_16]

    property p_pulses;
        state_reg != ST_OUT |=> sck_out && bit_cnt_reg <= 6'(WORD_BITS);
    endproperty
    a_pulses: assert property (p_pulses) else $error("clock not idle"); // [RULE_17]
endmodule

// ===== verification/adcso_host.sv
// Host side model of the serial clock wire
`timescale 1ns/1ps
module adcso_host (
    input wire logic clk,
    input wire logic host_drv,
    input wire logic host_sck,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic sck_pullup_en,
    output logic sck_wire
);
    logic last_lvl = 1'b0; // Last wire level
    // Resolve wire: device, host, pull-up, else drifting
    always_comb begin
        if (!sck_oe_n) sck_wire = sck_out;
        else if (host_drv) sck_wire = host_sck;
        else if (sck_pullup_en) sck_wire = 1'b1;
        else sck_wire = ~last_lvl;
    end
    // Remember level so a floating wire keeps changing
    always_ff @(posedge clk) last_lvl <= sck_wire;
endmodule

// ===== verification/adc_serial_output_control_test.sv
// Register and serial readout bench of the serial output control
`timescale 1ns/1ps
module adc_serial_output_control_test;
    import adcso_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic select_n = 1, freq_control_pin = 1, host_drv = 0, host_sck = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, w;
    logic pready, pslverr, err, sck_wire, sck_out, sck_oe_n, sck_pullup_en;
    logic sdo_out, sdo_oe_n, irq, prev;
    int mismatches = 0, checked = 0, rises;
    adcso_ctrl #(.CONV_50(200), .CONV_60(200), .CONV_ALT(200), .EXT_EDGES(200),
        .DET_LEN(64)) uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .select_n(select_n), .freq_control_pin(freq_control_pin),
        .sck_in(sck_wire), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .irq(irq));
    adcso_host host (.clk(clk), .host_drv(host_drv), .host_sck(host_sck), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .sck_pullup_en(sck_pullup_en), .sck_wire(sck_wire));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang cut short
    task automatic give_up();
        mismatches++;
        summarize();
    endtask
    // One APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Read and compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Poll state field
    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        do begin
            apb(1'b0, STATE_OFS, 32'h0);
            n++;
        end while (rd[1:0] !== s && n < 200);
        if (n >= 200) give_up();
    endtask
    // Wait for a clock wire level
    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (sck_wire !== v && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) give_up();
    endtask
    // Shift in bits at rising serial clock
    task automatic rd_word(input bit ext, input int nbits);
        w = 32'h0;
        for (int i = 0; i < nbits; i++) begin
            if (ext) begin
                repeat (4) @(posedge clk);
                host_sck <= 1'b1;
                w = {w[30:0], sdo_out};
                repeat (4) @(posedge clk);
                host_sck <= 1'b0;
            end else begin
                wait_lvl(1'b0);
                wait_lvl(1'b1);
                w = {w[30:0], sdo_out};
            end
        end
    endtask
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial forever #50 clk = ~clk;
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // Registers, unmapped place
        rdc(DATA_OFS, 32'h0);
        rdc(IRQ_MASK_OFS, 32'h0);
        apb(1'b1, DATA_OFS, 32'hffff_a5c3);
        rdc(DATA_OFS, 32'h3fff_a5c3);
        apb(1'b1, IRQ_MASK_OFS, 32'h7);
        rdc(8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
        check({31'h0, sdo_oe_n}, 32'h1);
        $display("test registers done");
        // Sleep, status, interrupt
        wait_state(2'h1);
        check({25'h0, rd[6:0]}, 32'h1);
        repeat (300) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rdc(IRQ_STS_OFS, 32'h1);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        $display("test sleep done");
        // Internal clock readout
        select_n <= 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, sdo_oe_n}, 32'h0);
        check({31'h0, sck_pullup_en}, 32'h1);
        rd_word(1'b0, 32);
        check(w, 32'h3fff_a5c3);
        apb(1'b0, STATE_OFS, 32'h0);
        check({30'h0, rd[1:0]}, 32'h0);
        check({31'h0, sdo_out}, 32'h1);
        select_n <= 1'b1;
        rises = 0;
        repeat (400) begin
            prev = sck_wire;
            @(posedge clk);
            if (!prev && sck_wire) rises++;
        end
        check(rises, 32'h0);
        $display("test internal done");
        // External clock, aborted then full word
        host_drv <= 1'b1;
        host_sck <= 1'b0;
        repeat (5) @(posedge clk);
        select_n <= 1'b0;
        rd_word(1'b1, 5);
        check(w, 32'h7);
        check({31'h0, sck_pullup_en}, 32'h0);
        select_n <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, sdo_oe_n}, 32'h1);
        rdc(IRQ_STS_OFS, 32'h7);
        apb(1'b0, STATE_OFS, 32'h0);
        check({29'h0, rd[3], rd[1:0]}, 32'h4);
        wait_state(2'h1);
        select_n <= 1'b0;
        rd_word(1'b1, 32);
        check(w, 32'h3fff_a5c3);
        select_n <= 1'b1;
        $display("test external done");
        // Null selection, then oscillator on frequency pin
        freq_control_pin <= 1'b0;
        repeat (80) @(posedge clk);
        apb(1'b0, STATE_OFS, 32'h0);
        check({30'h0, rd[6:5]}, 32'h1);
        repeat (40) begin
            freq_control_pin <= ~freq_control_pin;
            repeat (4) @(posedge clk);
        end
        apb(1'b0, STATE_OFS, 32'h0);
        check({29'h0, rd[6:4]}, 32'h7);
        $display("test oscillator done");
        summarize();
    end
endmodule
